/* include/dcg_pkg.sv */
// Package: register map, field positions and shared types of the gate bank
package dcg_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ADDR_RUN_GATES   = 12'h104;
    localparam logic [11:0] ADDR_SLEEP_GATES = 12'h114;
    localparam logic [11:0] ADDR_DEEP_GATES  = 12'h124;
    localparam logic [11:0] ADDR_RUN_CONFIG  = 12'h060;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h200;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h204;
    localparam logic [11:0] ADDR_FAULT_UNIT  = 12'h208;

    // ****************************************************************
    // Field positions and values
    // ****************************************************************
    localparam int          BIT_TIMER_TWO      = 18;
    localparam int          BIT_TIMER_ONE      = 17;
    localparam int          BIT_TIMER_ZERO     = 16;
    localparam int          BIT_TWOWIRE_ONE    = 14;
    localparam int          BIT_TWOWIRE_ZERO   = 12;
    localparam int          BIT_SYNC_ZERO      = 4;
    localparam int          BIT_ASYNC_ONE      = 1;
    localparam int          BIT_ASYNC_ZERO     = 0;
    localparam int          BIT_AUTO_GATING    = 27;
    localparam logic [31:0] GATE_WRITABLE_MASK = 32'h0007_5013;
    localparam logic [31:0] GATE_RESET_VALUE   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] CONFIG_MASK        = 32'h0800_0000;
    localparam int          NUM_UNITS          = 8;
    localparam int          IRQ_FAULT_BIT      = 0;
    localparam logic [31:0] IRQ_MASK_WIDTH     = 32'h0000_0001;

    // Power operating mode of the system
    typedef enum logic [2:0] {
        DCG_MODE_RUN   = 3'b001,
        DCG_MODE_SLEEP = 3'b010,
        DCG_MODE_DEEP  = 3'b100
    } dcg_mode_type;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dcg_req_type;

    // Access from the processor bus towards one gated unit
    typedef struct packed {
        logic [NUM_UNITS-1:0] sel;
        logic                 valid;
    } dcg_unit_access_type;

endpackage

/* hw/dcg_clock_gate.sv */
// Glitch-free clock gate for one peripheral unit
`timescale 1ns/1ps

module dcg_clock_gate (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic enable,
    output logic      unit_clk,
    output logic      unit_enable
);

    // ****************************************************************
    // Latch-free gating
    // ****************************************************************
    // Enable is retimed on the falling edge so it only changes while the
    // clock is low; the AND then never cuts a high phase short.
    logic en_low;

    always_ff @(negedge ref_clk) begin
        if (!reset_n) begin
            en_low <= 1'b0;
        end else begin
            en_low <= enable;
        end
    end

    assign unit_clk = ref_clk & en_low;

    // Registered enable the unit uses as its active-high enable
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            unit_enable <= 1'b0;
        end else begin
            unit_enable <= enable;
        end
    end

endmodule // dcg_clock_gate

/* hw/dcg_gate_bank.sv */
// Top: run, sleep and deep-sleep unit clock gates with fault reporting
`timescale 1ns/1ps


module dcg_gate_bank (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire dcg_pkg::dcg_mode_type        power_mode,
    input  wire logic [11:0]                  reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [31:0]                  reg_rdata,
    input  wire dcg_pkg::dcg_unit_access_type unit_access,
    output logic                              unit_ack,
    output logic                              bus_fault,
    output logic      [7:0]                   unit_enable,
    output logic      [7:0]                   unit_clk,
    output logic                              irq
);
    import dcg_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [31:0] run_unit_clock_gates_one;
    logic [31:0] sleep_unit_clock_gates_one;
    logic [31:0] deep_sleep_unit_clock_gates_one;
    logic [31:0] run_clock_configuration;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [7:0]  fault_unit;
    dcg_req_type req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire hit_run    = (req.addr == ADDR_RUN_GATES);
    wire hit_sleep  = (req.addr == ADDR_SLEEP_GATES);
    wire hit_deep   = (req.addr == ADDR_DEEP_GATES);
    wire hit_config = (req.addr == ADDR_RUN_CONFIG);
    wire hit_status = (req.addr == ADDR_IRQ_STATUS);
    wire hit_mask   = (req.addr == ADDR_IRQ_MASK);
    wire hit_fault  = (req.addr == ADDR_FAULT_UNIT);

    // Reserved bits never store, so they read back as zero
    wire [31:0] gate_wdata = req.wdata & GATE_WRITABLE_MASK;

    // ****************************************************************
    // Active gate selection
    // ****************************************************************
    // Auto gating off means the run gates stay in charge in every mode.
    wire        auto_gating = run_clock_configuration[BIT_AUTO_GATING];
    wire [31:0] active_gates =
        (auto_gating && power_mode == DCG_MODE_DEEP)  ?
            deep_sleep_unit_clock_gates_one :
        (auto_gating && power_mode == DCG_MODE_SLEEP) ?
            sleep_unit_clock_gates_one :
            run_unit_clock_gates_one;

    // Compact per-unit enables in the order of the unit vector
    wire [7:0] unit_gate = {
        active_gates[BIT_TIMER_TWO],
        active_gates[BIT_TIMER_ONE],
        active_gates[BIT_TIMER_ZERO],
        active_gates[BIT_TWOWIRE_ONE],
        active_gates[BIT_TWOWIRE_ZERO],
        active_gates[BIT_SYNC_ZERO],
        active_gates[BIT_ASYNC_ONE],
        active_gates[BIT_ASYNC_ZERO]
    };

    // An access hitting a gated-off unit faults instead of completing
    wire [7:0] blocked     = unit_access.sel & ~unit_gate;
    wire       fault_now   = unit_access.valid && (blocked != 8'h00);
    wire       ack_now     = unit_access.valid && (blocked == 8'h00);
    wire [31:0] irq_events = {31'h0000_0000, fault_now};

    // ****************************************************************
    // Gate registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            run_unit_clock_gates_one        <= GATE_RESET_VALUE;
            sleep_unit_clock_gates_one      <= GATE_RESET_VALUE;
            deep_sleep_unit_clock_gates_one <= GATE_RESET_VALUE;
            run_clock_configuration         <= CONFIG_RESET_VALUE;
        end else begin
            if (req.wr && hit_run) begin
                run_unit_clock_gates_one <= gate_wdata;
            end
            if (req.wr && hit_sleep) begin
                sleep_unit_clock_gates_one <= gate_wdata;
            end
            if (req.wr && hit_deep) begin
                deep_sleep_unit_clock_gates_one <= gate_wdata;
            end
            if (req.wr && hit_config) begin
                run_clock_configuration <= req.wdata & CONFIG_MASK;
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // New events win over a write-one clear in the same cycle.
    wire [31:0] status_clear =
        (req.wr && hit_status) ? req.wdata : 32'h0000_0000;
    wire [31:0] next_irq_status =
        (irq_status & ~status_clear) | irq_events;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_status <= 32'h0000_0000;
            irq_mask   <= 32'h0000_0000;
            fault_unit <= 8'h00;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status & IRQ_MASK_WIDTH;
            if (req.wr && hit_mask) begin
                irq_mask <= req.wdata & IRQ_MASK_WIDTH;
            end
            if (fault_now) begin
                fault_unit <= blocked;     // Last offending unit set
            end
            irq <= |(next_irq_status & IRQ_MASK_WIDTH & irq_mask);
        end
    end

    // ****************************************************************
    // Read data and access answer
    // ****************************************************************
    // Unmapped addresses read as zero; reads have no side effect.
    wire [31:0] read_mux =
        hit_run    ? run_unit_clock_gates_one :
        hit_sleep  ? sleep_unit_clock_gates_one :
        hit_deep   ? deep_sleep_unit_clock_gates_one :
        hit_config ? run_clock_configuration :
        hit_status ? irq_status :
        hit_mask   ? irq_mask :
        hit_fault  ? {24'h00_0000, fault_unit} :
                     32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
            unit_ack  <= 1'b0;
            bus_fault <= 1'b0;
        end else begin
            reg_rdata <= req.rd ? read_mux : 32'h0000_0000;
            unit_ack  <= ack_now;
            bus_fault <= fault_now;
        end
    end

    // ****************************************************************
    // Per-unit clock gates
    // ****************************************************************
    // unit_clk is a gated clock, not a flop output: gating must follow
    // the clock itself.
    for (genvar i = 0; i < NUM_UNITS; i++) begin : g_gate
        dcg_clock_gate u_gate (
            .ref_clk     (ref_clk),
            .reset_n     (reset_n),
            .enable      (unit_gate[i]),
            .unit_clk    (unit_clk[i]),
            .unit_enable (unit_enable[i])
        );
    end

endmodule // dcg_gate_bank

/* sim/dcg_gate_bank_props.sv */
// Checker: port-level properties of the gate bank
`timescale 1ns/1ps

module dcg_gate_bank_props (
    input wire logic                         ref_clk,
    input wire logic                         reset_n,
    input wire dcg_pkg::dcg_mode_type        power_mode,
    input wire logic [11:0]                  reg_addr,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [31:0]                  reg_rdata,
    input wire dcg_pkg::dcg_unit_access_type unit_access,
    input wire logic                         unit_ack,
    input wire logic                         bus_fault,
    input wire logic [7:0]                   unit_enable,
    input wire logic [7:0]                   unit_clk,
    input wire logic                         irq
);
    import dcg_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Enables lag the gates by a cycle, so judge only settled accesses
    sequence s_calm;
        !$past(reg_wr) && $stable(power_mode);
    endsequence
    property p_fault;
        (unit_access.valid && (unit_access.sel & unit_enable) == 8'h00)
            ##0 s_calm |=> bus_fault && !unit_ack;
    endproperty
    property p_ack;
        (unit_access.valid && (unit_access.sel & unit_enable) != 8'h00)
            ##0 s_calm |=> unit_ack && !bus_fault;
    endproperty
    property p_resp;
        (bus_fault || unit_ack) |-> $past(unit_access.valid);
    endproperty
    property p_rsvd;
        $past(reg_rd) && $past(reg_addr) == ADDR_DEEP_GATES
            |-> (reg_rdata & ~GATE_WRITABLE_MASK) == 32'h0000_0000;
    endproperty
    property p_rst;
        $rose(reset_n) |-> unit_enable == 8'h00 && !irq;
    endproperty
    // A short reset clears the enables too, and the release edge already
    // sees that change while reset is no longer low
    property p_follow;
        $changed(unit_enable)
            |-> $past(reg_wr, 2) || $past(power_mode) != $past(power_mode, 2)
                || !$past(reset_n);
    endproperty
    // The gate leads the enable by half a cycle, hence three samples
    property p_clk_off;
        @(negedge ref_clk) (unit_enable == 8'h00) [*3]
            |-> $past(unit_clk) == 8'h00;
    endproperty
    property p_irq;
        $rose(irq) |-> bus_fault || $past(reg_wr) || $past(reg_wr, 2);
    endproperty
    a_fault: assert property (p_fault)
        else $error("gated unit not faulted");
    a_ack: assert property (p_ack)
        else $error("clocked unit not acknowledged");
    a_resp: assert property (p_resp)
        else $error("answer without access");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved gate bit reads one");
    a_rst: assert property (p_rst)
        else $error("unit enabled out of reset");
    a_follow: assert property (p_follow)
        else $error("enable moved without cause");
    a_clk_off: assert property (p_clk_off)
        else $error("disabled unit still clocked");
    a_irq: assert property (p_irq)
        else $error("interrupt without cause");
    c_fault: cover property (bus_fault);
    c_ack: cover property (unit_ack);
    c_irq: cover property ($rose(irq));
endmodule // dcg_gate_bank_props

bind dcg_gate_bank dcg_gate_bank_props u_props (
    .ref_clk, .reset_n, .power_mode, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .unit_access, .unit_ack, .bus_fault, .unit_enable,
    .unit_clk, .irq
);

/* sim/dcg_bus_model.sv */
// Partner: processor bus issuing accesses to the gated units
`timescale 1ns/1ps

module dcg_bus_model (
    input  wire logic                    ref_clk,
    input  wire logic                    go,
    input  wire logic [2:0]              unit_idx,
    output dcg_pkg::dcg_unit_access_type unit_access
);
    import dcg_pkg::*;
    initial unit_access = '0;
    // One-cycle access per request; select scrambles while idle so a
    // stale target never passes for a live one
    always @(posedge ref_clk) begin
        unit_access.valid <= go;
        unit_access.sel   <= go ? 8'h01 << unit_idx : ~unit_access.sel;
    end
endmodule // dcg_bus_model

/* sim/dcg_gate_bank_test.sv */
// Testbench: register map, gating and fault checks of the gate bank
`timescale 1ns/1ps

module dcg_gate_bank_test;
    import dcg_pkg::*;
    logic                ref_clk = 1'b0;
    logic                reset_n = 1'b0;
    dcg_mode_type        power_mode = DCG_MODE_RUN;
    logic [11:0]         reg_addr = 12'h000;
    logic [31:0]         reg_wdata = 32'h0000_0000;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic                go = 1'b0;
    logic [2:0]          unit_idx = 3'h0;
    logic [31:0]         reg_rdata;
    dcg_unit_access_type unit_access;
    logic                unit_ack;
    logic                bus_fault;
    logic                irq;
    logic [7:0]          unit_enable;
    logic [7:0]          unit_clk;
    int                  err_count = 0;
    int                  checks = 0;
    // Gate bit of each unit index, async zero first
    int                  pos [8] = '{0, 1, 4, 12, 14, 16, 17, 18};
    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;
    dcg_gate_bank u_dut (
        .ref_clk, .reset_n, .power_mode, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .unit_access, .unit_ack, .bus_fault,
        .unit_enable, .unit_clk, .irq
    );
    dcg_bus_model u_bus (.ref_clk, .go, .unit_idx, .unit_access);
    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    // The model launches a cycle after go; the answer a cycle later
    task automatic acc(input int i, input logic flt);
        @(posedge ref_clk);
        go <= 1'b1;
        unit_idx <= i[2:0];
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        #1 chk("bus_fault", {31'h0, bus_fault}, {31'h0, flt});
        chk("unit_ack", {31'h0, unit_ack}, {31'h0, ~flt});
    endtask
    task automatic en_is(input logic [7:0] e);
        chk("unit_enable", {24'h0, unit_enable}, {24'h0, e});
    endtask
    task automatic give_verdict();
        $display("Mismatches %0d in %0d checks", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog: about twenty times the expected run length
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(ADDR_DEEP_GATES, GATE_RESET_VALUE);
        en_is(8'h00);
        acc(0, 1'b1);
        wr(ADDR_RUN_CONFIG, CONFIG_MASK);
        @(posedge ref_clk) power_mode <= DCG_MODE_DEEP;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_DEEP_GATES, 32'h1 << pos[i]);
            rd(ADDR_DEEP_GATES, 32'h1 << pos[i]);
            en_is(8'h01 << i);
            #5 chk("unit_clk", {24'h0, unit_clk}, 32'h1 << i);
            acc(i, 1'b0);
            acc((i + 1) % 8, 1'b1);
        end
        wr(ADDR_DEEP_GATES, 32'hFFFF_FFFF);
        rd(ADDR_DEEP_GATES, GATE_WRITABLE_MASK);
        en_is(8'hFF);
        wr(ADDR_RUN_GATES, 32'h0000_0013);
        @(posedge ref_clk) power_mode <= DCG_MODE_SLEEP;
        rd(ADDR_SLEEP_GATES, 32'h0000_0000);
        en_is(8'h00);
        wr(ADDR_RUN_CONFIG, 32'h0000_0000);
        rd(ADDR_RUN_GATES, 32'h0000_0013);
        en_is(8'h07);
        // Auto gating in run mode still leaves the run gates in charge
        @(posedge ref_clk) power_mode <= DCG_MODE_RUN;
        wr(ADDR_RUN_CONFIG, CONFIG_MASK);
        rd(ADDR_RUN_CONFIG, CONFIG_MASK);
        en_is(8'h07);
        // A masked fault stays silent until the mask opens
        acc(7, 1'b1);
        rd(ADDR_FAULT_UNIT, 32'h0000_0080);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h0000_0001);
        rd(ADDR_IRQ_STATUS, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(12'h3FC, 32'h0000_0000);
        // Reset again in mid-run
        @(posedge ref_clk) reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(ADDR_RUN_GATES, GATE_RESET_VALUE);
        en_is(8'h00);
        give_verdict();
    end
endmodule // dcg_gate_bank_test
